//--- rtl/irf_pkg.sv
/*
 * constants shared by the interrupt request flag block: register offsets,
 * flag positions, field layouts, reset values and bus answers.
 * assumes a 32-bit axi4-lite register bus with word-aligned registers.
 */
package irf_pkg;
   // ****************************************************************
   // register map (byte addresses)
   // ****************************************************************
   localparam int IRF_AXI_AW = 32;
   localparam logic [31:0] IRF_OFS_REQ_A = 32'h0000_0000;
   localparam logic [31:0] IRF_OFS_REQ_B = 32'h0000_0004;
   localparam logic [31:0] IRF_OFS_WAKE = 32'h0000_0008;
   localparam logic [31:0] IRF_OFS_EDGE = 32'h0000_000C;
   localparam logic [31:0] IRF_OFS_EN_A = 32'h0000_0010;
   localparam logic [31:0] IRF_OFS_EN_B = 32'h0000_0014;
   localparam logic [31:0] IRF_OFS_PIN_EDGE = 32'h0000_0018;
   localparam logic [31:0] IRF_OFS_PIN_ASSIGN = 32'h0000_001C;
   // ****************************************************************
   // flag positions
   // ****************************************************************
   localparam int IRF_BIT_TIMER_A = 7;
   localparam int IRF_BIT_A_FIXED = 5;
   localparam int IRF_BIT_EVENT_PIN = 2;
   localparam int IRF_BIT_WAKE_EN = 5;
   localparam int IRF_BIT_DT = 7;
   localparam int IRF_BIT_CONV = 6;
   localparam int IRF_BIT_TG = 4;
   localparam int IRF_BIT_TFH = 3;
   localparam int IRF_BIT_TFL = 2;
   localparam int IRF_BIT_TC = 1;
   localparam int IRF_BIT_EC = 0;
   // external pins 0,1,2,3 land on these flag bits
   localparam int IRF_EXT_BIT [4] = '{0, 1, 3, 4};
   // ****************************************************************
   // masks and reset values
   // ****************************************************************
   localparam logic [7:0] IRF_REQ_A_MASK = 8'h9F;
   localparam logic [7:0] IRF_REQ_B_MASK = 8'hDF;
   localparam logic [7:0] IRF_EN_A_MASK = 8'hBF;
   localparam logic [7:0] IRF_EN_B_MASK = 8'hDF;
   localparam logic [7:0] IRF_FIXED_ONE = 8'h20;
   localparam logic [7:0] IRF_RST_FLAGS = 8'h00;
   localparam logic [7:0] IRF_RST_EDGE = 8'h00;
   localparam logic [7:0] IRF_RST_EN = 8'h00;
   localparam logic [6:0] IRF_RST_PIN_EDGE = 7'h00;
   localparam logic [15:0] IRF_RST_ASSIGN = 16'h0000;
   // ****************************************************************
   // pin configuration fields
   // ****************************************************************
   localparam int IRF_EVT_MODE_LSB = 4;
   localparam int IRF_CAP_EDGE_BIT = 6;
   localparam int IRF_EVT_ASSIGN_BIT = 4;
   localparam int IRF_CAP_ASSIGN_BIT = 5;
   localparam int IRF_WAKE_ASSIGN_LSB = 8;
   localparam logic [1:0] IRF_EVT_RISE = 2'h1;
   localparam logic [1:0] IRF_EVT_BOTH = 2'h2;
   // ****************************************************************
   // bus answers
   // ****************************************************************
   localparam logic [1:0] IRF_RESP_OKAY = 2'h0;
   localparam logic [1:0] IRF_RESP_SLVERR = 2'h2;
endpackage

//--- rtl/irf_edge_det.sv
/*
 * two-flop synchroniser and edge detector for one pin.
 * assumes the pin is asynchronous to clk_sys; edges are reported only
 * once the pipeline has filled after reset, so an idle-high pin does not
 * look like a rising edge.
 */
`timescale 1ns/1ps
module irf_edge_det (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic pin_raw,
   input wire logic rise_en,
   input wire logic fall_en,
   output logic edge_pulse
);
   logic sync_a;
   logic sync_b;
   logic last;
   logic [2:0] fill;

   // ****************************************************************
   // synchroniser, history and fill tracking
   // ****************************************************************
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         last <= 1'b0;
         fill <= 3'h0;
      end else begin
         sync_a <= pin_raw;
         sync_b <= sync_a;
         last <= sync_b;
         fill <= {fill[1:0], 1'b1};
      end
   end

   // one-cycle pulse on the chosen edge(s)
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         edge_pulse <= 1'b0;
      end else begin
         edge_pulse <= fill[2] & ((rise_en & sync_b & ~last) |
                                  (fall_en & ~sync_b & last));
      end
   end
endmodule

//--- rtl/irf_top.sv
/*
 * sticky interrupt request flags, wakeup edge select, enables and pin
 * configuration behind an axi4-lite slave.
 * assumes peripheral event inputs are one-cycle pulses or levels on
 * clk_sys; pin inputs are asynchronous and synchronised here.
 */
// Local design decisions: register access over AXI4-Lite and the address map.
// Notes on behaviour
// RULE1: timer a overflow sets flag a bit 7
// RULE2: writing 0 clears flag; 1 keeps it
// RULE3: software writes 0 to reserved bit 6
// RULE4: flag a bit 5 reads 1, unwritable
// RULE5: external pin edge sets its flag
// RULE6: event pin edge sets flag a bit 2
// RULE7: acceptance never clears peripheral flags
// RULE8: sleep direct transfer with enable sets bit 7
// RULE9: conversion end sets converter flag
// RULE10: software writes 0 to reserved bit 5
// RULE11: capture edge or enabled overflow sets timer g
// RULE12: timer f high match by mode sets bit 3
// RULE13: low byte match, 8-bit mode only
// RULE14: timer c over/underflow sets bit 1
// RULE15: event counter overflow by mode sets bit 0
// RULE16: eight wakeup flags set by pin edges
// RULE17: wakeup flags clear only by software
// RULE18: wakeup edge select register, bit per pin
// RULE19: edge select resets to zero
// RULE20: all request flags reset to zero
// RULE21: select 0 falling, 1 rising
// RULE22: request forwarded only while enabled
// RULE23: event pin senses rise, fall or both
// RULE24: hardware set beats same-cycle clear
`timescale 1ns/1ps
module irf_top (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [irf_pkg::IRF_AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [irf_pkg::IRF_AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic timer_a_ovf,
   input wire logic sleep_direct_transfer,
   input wire logic direct_transfer_on,
   input wire logic conversion_start_flag,
   input wire logic timer_g_ovf,
   input wire logic overflow_irq_enable,
   input wire logic timer_f_16bit_mode,
   input wire logic [7:0] timer_f_counter_high,
   input wire logic [7:0] timer_f_compare_high,
   input wire logic [7:0] timer_f_counter_low,
   input wire logic [7:0] timer_f_compare_low,
   input wire logic timer_c_ovf,
   input wire logic timer_c_udf,
   input wire logic event_16bit_mode,
   input wire logic event_count_high_ovf,
   input wire logic event_count_low_ovf,
   input wire logic [3:0] external_irq_pin,
   input wire logic event_counter_irq_pin,
   input wire logic capture_input_pin,
   input wire logic [7:0] wakeup_pin,
   output logic [7:0] irq_request_a,
   output logic [7:0] irq_request_b
);
   import irf_pkg::*;

   logic [7:0] flags_a;
   logic [7:0] flags_b;
   logic [7:0] wakeup_req_flags;
   logic [7:0] wakeup_edge_bits;
   logic [7:0] enable_register_a;
   logic [7:0] enable_register_b;
   logic [6:0] pin_edge_cfg;
   logic [15:0] pin_assign;
   logic [3:0] ext_edge;
   logic [7:0] wake_edge;
   logic evt_edge;
   logic cap_edge;
   logic [7:0] set_a;
   logic [7:0] set_b;
   logic [7:0] set_w;
   logic conv_busy_q;
   logic tfh_hit_q;
   logic tfl_hit_q;
   logic tfh_hit;
   logic tfl_hit;
   logic aw_held;
   logic w_held;
   logic [31:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic [31:0] wr_addr;
   logic [31:0] wr_data;
   logic wr_lane0;
   logic do_write;
   logic [7:0] keep_a;
   logic [7:0] keep_b;
   logic [7:0] keep_w;
   logic [7:0] wake_sel;

   // ****************************************************************
   // pin edge detection
   // ****************************************************************
   // edge select 1 picks rising, 0 picks falling
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_ext
         irf_edge_det u_det (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .pin_raw(external_irq_pin[gi]),
            .rise_en(pin_edge_cfg[gi]),
            .fall_en(~pin_edge_cfg[gi]),
            .edge_pulse(ext_edge[gi])
         );
      end
      // RULE21: wakeup edge polarity
      for (gi = 0; gi < 8; gi++) begin : g_wake
         irf_edge_det u_det (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .pin_raw(wakeup_pin[gi]),
            .rise_en(wakeup_edge_bits[gi]),
            .fall_en(~wakeup_edge_bits[gi]),
            .edge_pulse(wake_edge[gi])
         );
      end
   endgenerate

   // RULE23: event pin rise, fall or both
   irf_edge_det u_evt (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .pin_raw(event_counter_irq_pin),
      .rise_en(pin_edge_cfg[IRF_EVT_MODE_LSB +: 2] != 2'h0),
      .fall_en(pin_edge_cfg[IRF_EVT_MODE_LSB +: 2] != IRF_EVT_RISE),
      .edge_pulse(evt_edge)
   );

   irf_edge_det u_cap (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .pin_raw(capture_input_pin),
      .rise_en(pin_edge_cfg[IRF_CAP_EDGE_BIT]),
      .fall_en(~pin_edge_cfg[IRF_CAP_EDGE_BIT]),
      .edge_pulse(cap_edge)
   );

   // ****************************************************************
   // peripheral event conditioning
   // ****************************************************************
   // RULE12: high match depends on timer width
   assign tfh_hit = timer_f_16bit_mode ?
      (timer_f_counter_high == timer_f_compare_high &&
       timer_f_counter_low == timer_f_compare_low) :
      (timer_f_counter_high == timer_f_compare_high);
   // RULE13: low match only in 8-bit mode
   assign tfl_hit = ~timer_f_16bit_mode &
      (timer_f_counter_low == timer_f_compare_low);

   // history so a long match or busy level sets only once
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         conv_busy_q <= 1'b0;
         tfh_hit_q <= 1'b0;
         tfl_hit_q <= 1'b0;
      end else begin
         conv_busy_q <= conversion_start_flag;
         tfh_hit_q <= tfh_hit;
         tfl_hit_q <= tfl_hit;
      end
   end

   // set vectors for all three flag registers
   always_comb begin
      set_a = 8'h00;
      set_b = 8'h00;
      // RULE1: timer a overflow
      set_a[IRF_BIT_TIMER_A] = timer_a_ovf;
      // RULE5: assigned external pin edges
      for (int i = 0; i < 4; i++) begin
         set_a[IRF_EXT_BIT[i]] = ext_edge[i] & pin_assign[i];
      end
      // RULE6: assigned event pin edge
      set_a[IRF_BIT_EVENT_PIN] = evt_edge & pin_assign[IRF_EVT_ASSIGN_BIT];
      // RULE8: direct transfer while enabled
      set_b[IRF_BIT_DT] = sleep_direct_transfer & direct_transfer_on;
      // RULE9: busy flag falling ends a conversion
      set_b[IRF_BIT_CONV] = conv_busy_q & ~conversion_start_flag;
      // RULE11: capture edge or enabled overflow
      set_b[IRF_BIT_TG] = (cap_edge & pin_assign[IRF_CAP_ASSIGN_BIT]) |
                          (timer_g_ovf & overflow_irq_enable);
      set_b[IRF_BIT_TFH] = tfh_hit & ~tfh_hit_q;
      set_b[IRF_BIT_TFL] = tfl_hit & ~tfl_hit_q;
      // RULE14: timer c either direction
      set_b[IRF_BIT_TC] = timer_c_ovf | timer_c_udf;
      // RULE15: event counter overflow by mode
      set_b[IRF_BIT_EC] = event_count_high_ovf |
                          (~event_16bit_mode & event_count_low_ovf);
      // RULE16: assigned wakeup pin edges
      set_w = wake_edge & pin_assign[IRF_WAKE_ASSIGN_LSB +: 8];
   end

   // ****************************************************************
   // axi4-lite write channel
   // ****************************************************************
   // address and data are taken in either order, then held until paired
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held & ~s_axi_bvalid;
   assign wr_addr = aw_held ? aw_addr_q : s_axi_awaddr;
   assign wr_data = w_held ? w_data_q : s_axi_wdata;
   assign wr_lane0 = w_held ? w_strb_q[0] : s_axi_wstrb[0];
   assign do_write = (aw_held | s_axi_awvalid) & (w_held | s_axi_wvalid) &
                     ~s_axi_bvalid;

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_q <= 32'h0000_0000;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else if (do_write) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
      end
   end

   // response one cycle after the pair, slverr off the map
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= IRF_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= mapped(wr_addr) ? IRF_RESP_OKAY : IRF_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   function automatic logic mapped(input logic [31:0] a);
      mapped = a[31:5] == 27'h0 && a[1:0] == 2'h0;
   endfunction

   // ****************************************************************
   // request flags
   // ****************************************************************
   // RULE2: zero bits clear, one bits keep
   always_comb begin
      keep_a = 8'hFF;
      keep_b = 8'hFF;
      keep_w = 8'hFF;
      if (do_write && wr_lane0) begin
         if (wr_addr == IRF_OFS_REQ_A) keep_a = wr_data[7:0];
         if (wr_addr == IRF_OFS_REQ_B) keep_b = wr_data[7:0];
         if (wr_addr == IRF_OFS_WAKE) keep_w = wr_data[7:0];
      end
   end

   // RULE24: or-ing the set after the clear lets the set win
   // RULE7: nothing but a software write clears these
   // RULE17: wakeup flags share the same path
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         // RULE20: flags start clear
         flags_a <= IRF_RST_FLAGS;
         flags_b <= IRF_RST_FLAGS;
         wakeup_req_flags <= IRF_RST_FLAGS;
      end else begin
         flags_a <= ((flags_a & keep_a) | set_a) & IRF_REQ_A_MASK;
         flags_b <= ((flags_b & keep_b) | set_b) & IRF_REQ_B_MASK;
         wakeup_req_flags <= (wakeup_req_flags & keep_w) | set_w;
      end
   end

   // ****************************************************************
   // control registers
   // ****************************************************************
   // RULE18: plain read/write edge select
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         // RULE19: edge select starts at zero
         wakeup_edge_bits <= IRF_RST_EDGE;
         enable_register_a <= IRF_RST_EN;
         enable_register_b <= IRF_RST_EN;
         pin_edge_cfg <= IRF_RST_PIN_EDGE;
         pin_assign <= IRF_RST_ASSIGN;
      end else if (do_write) begin
         // reserved enable bits are masked so they always stay 0
         if (wr_addr == IRF_OFS_EDGE && wr_lane0)
            wakeup_edge_bits <= wr_data[7:0];
         if (wr_addr == IRF_OFS_EN_A && wr_lane0)
            enable_register_a <= wr_data[7:0] & IRF_EN_A_MASK;
         if (wr_addr == IRF_OFS_EN_B && wr_lane0)
            enable_register_b <= wr_data[7:0] & IRF_EN_B_MASK;
         if (wr_addr == IRF_OFS_PIN_EDGE && wr_lane0)
            pin_edge_cfg <= wr_data[6:0];
         if (wr_addr == IRF_OFS_PIN_ASSIGN && wr_lane0)
            pin_assign[7:0] <= wr_data[7:0];
         if (wr_addr == IRF_OFS_PIN_ASSIGN && s_axi_wstrb_hi())
            pin_assign[15:8] <= wr_data[15:8];
      end
   end

   function automatic logic s_axi_wstrb_hi();
      s_axi_wstrb_hi = w_held ? w_strb_q[1] : s_axi_wstrb[1];
   endfunction

   // ****************************************************************
   // axi4-lite read channel
   // ****************************************************************
   assign s_axi_arready = ~s_axi_rvalid;

   // RULE4: fixed one merged into the read view
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= IRF_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= mapped(s_axi_araddr) ? IRF_RESP_OKAY :
                        IRF_RESP_SLVERR;
         unique case (s_axi_araddr)
            IRF_OFS_REQ_A: s_axi_rdata <= {24'h0, flags_a | IRF_FIXED_ONE};
            IRF_OFS_REQ_B: s_axi_rdata <= {24'h0, flags_b};
            IRF_OFS_WAKE: s_axi_rdata <= {24'h0, wakeup_req_flags};
            IRF_OFS_EDGE: s_axi_rdata <= {24'h0, wakeup_edge_bits};
            IRF_OFS_EN_A: s_axi_rdata <= {24'h0, enable_register_a};
            IRF_OFS_EN_B: s_axi_rdata <= {24'h0, enable_register_b};
            IRF_OFS_PIN_EDGE: s_axi_rdata <= {25'h0, pin_edge_cfg};
            IRF_OFS_PIN_ASSIGN: s_axi_rdata <= {16'h0, pin_assign};
            default: s_axi_rdata <= 32'h0000_0000;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************************************
   // request forwarding
   // ****************************************************************
   // the wakeup group shares one enable at bit 5 of the first register
   assign wake_sel = {2'h0, |wakeup_req_flags, 5'h00};

   // RULE22: only enabled flags are forwarded
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         irq_request_a <= 8'h00;
         irq_request_b <= 8'h00;
      end else begin
         irq_request_a <= (flags_a | wake_sel) & enable_register_a;
         irq_request_b <= flags_b & enable_register_b;
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   sequence s_clear_a7;
      do_write && wr_lane0 && wr_addr == IRF_OFS_REQ_A && !wr_data[7];
   endsequence

   a_timer_a_set: assert property ( // RULE1
      timer_a_ovf |=> flags_a[IRF_BIT_TIMER_A])
      else $error("timer a overflow did not set its flag");
   a_one_keeps: assert property ( // RULE2
      do_write && wr_lane0 && wr_addr == IRF_OFS_REQ_A &&
      flags_a[IRF_BIT_TIMER_A] && wr_data[7] |=> flags_a[IRF_BIT_TIMER_A])
      else $error("writing one changed a set flag");
   a_fixed_one: assert property ( // RULE4
      s_axi_arvalid && s_axi_arready && s_axi_araddr == IRF_OFS_REQ_A
      |=> s_axi_rdata[IRF_BIT_A_FIXED])
      else $error("fixed bit did not read as one");
   a_ext_pin: assert property ( // RULE5
      ext_edge[0] && pin_assign[0] |=> flags_a[0])
      else $error("external pin edge lost");
   a_event_pin: assert property ( // RULE6
      $rose(flags_a[IRF_BIT_EVENT_PIN]) |->
      $past(evt_edge && pin_assign[IRF_EVT_ASSIGN_BIT]))
      else $error("event pin flag set without its edge");
   a_flag_hold: assert property ( // RULE7
      $fell(flags_a[IRF_BIT_TIMER_A]) |-> $past(keep_a[IRF_BIT_TIMER_A]) == 0)
      else $error("flag fell without a software clear");
   a_dt_gate: assert property ( // RULE8
      $rose(flags_b[IRF_BIT_DT]) |-> $past(direct_transfer_on))
      else $error("direct transfer flag set while disabled");
   a_conv_end: assert property ( // RULE9
      conv_busy_q && !conversion_start_flag |=> flags_b[IRF_BIT_CONV])
      else $error("conversion end did not set flag");
   a_tfl_mode: assert property ( // RULE13
      $rose(flags_b[IRF_BIT_TFL]) |-> !$past(timer_f_16bit_mode))
      else $error("low match flag set in 16-bit mode");
   a_ec_mode: assert property ( // RULE15
      event_16bit_mode && event_count_low_ovf && !event_count_high_ovf &&
      !flags_b[IRF_BIT_EC] && keep_b[IRF_BIT_EC] |=> !flags_b[IRF_BIT_EC])
      else $error("low byte overflow set flag in 16-bit mode");
   a_wake_set: assert property ( // RULE16
      wake_edge[7] && pin_assign[15] |=> wakeup_req_flags[7])
      else $error("wakeup edge lost");
   a_edge_reset: assert property ( // RULE19
      disable iff (1'b0) !nrst |=> wakeup_edge_bits == 8'h00 &&
      flags_a == 8'h00 ##1 s_axi_rdata == 32'h0)
      else $error("reset did not clear registers");
   a_enable_gate: assert property ( // RULE22
      irq_request_a[0] |->
      $past(enable_register_a[0] && flags_a[0]))
      else $error("request forwarded while disabled");
   a_set_wins: assert property ( // RULE24
      s_clear_a7 and timer_a_ovf |=> flags_a[IRF_BIT_TIMER_A] [*2])
      else $error("set lost against a clear");
endmodule

//--- tb/irf_src.sv
/* partner model: the on-chip peripherals that pulse request events.
   assumes clk_sys from the bench; every event lasts one cycle. */
`timescale 1ns/1ps
module irf_src (
   input wire logic clk_sys,
   output logic [6:0] ev
);
   initial ev = 7'h00;
   task automatic fire(input logic [6:0] m);
      ev <= m;
      @(posedge clk_sys);
      ev <= 7'h00;
   endtask
endmodule

//--- tb/tb.sv
/* bench: axi4-lite master, event partner, queue scoreboard on reads.
   assumes the slave answers well inside the watchdog span. */
`timescale 1ns/1ps
module tb;
   import irf_pkg::*;
   logic clk_sys, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb, external_irq_pin;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic timer_a_ovf, sleep_direct_transfer, direct_transfer_on;
   logic conversion_start_flag, timer_g_ovf, overflow_irq_enable;
   logic timer_f_16bit_mode, timer_c_ovf, timer_c_udf, event_16bit_mode;
   logic event_count_high_ovf, event_count_low_ovf, event_counter_irq_pin;
   logic capture_input_pin;
   logic [7:0] timer_f_counter_high, timer_f_compare_high;
   logic [7:0] timer_f_counter_low, timer_f_compare_low, wakeup_pin;
   logic [7:0] irq_request_a, irq_request_b, lf;
   logic [6:0] ev;
   logic [33:0] q [$];
   int error_cnt = 0;
   int n_checks = 0;
   assign {event_count_low_ovf, event_count_high_ovf, timer_c_udf,
      timer_c_ovf, timer_g_ovf, sleep_direct_transfer, timer_a_ovf} = ev;
   irf_top irf_top_inst (.*);
   irf_src irf_src_inst (.clk_sys(clk_sys), .ev(ev));
   // ****************************************************************
   // helpers
   // ****************************************************************
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input logic [33:0] s, input logic [33:0] e);
      n_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // write: hold each channel until its own ready, then wait for b
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bit done;
      done = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done) begin
         @(posedge clk_sys);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) begin
            chk({32'h0, s_axi_bresp},
               {32'h0, (a >= 32'h20) ? IRF_RESP_SLVERR : IRF_RESP_OKAY});
            s_axi_bready <= 1'b0;
            done = 1;
         end
      end
      // let an edge pass so the next call never re-drives this step
      @(posedge clk_sys);
   endtask
   // read: note the expected answer, unmapped places give an error
   task automatic rd(input logic [31:0] a, input logic [31:0] d);
      bit done;
      done = 0;
      q.push_back({(a >= 32'h20) ? IRF_RESP_SLVERR : IRF_RESP_OKAY, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done) begin
         @(posedge clk_sys);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            s_axi_rready <= 1'b0;
            done = 1;
         end
      end
      @(posedge clk_sys);
   endtask
   // monitor pairs each read answer with the oldest note
   always @(posedge clk_sys) begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
         chk({s_axi_rresp, s_axi_rdata}, q.pop_front());
   end
   // watchdog sized well above the whole sequence
   initial begin
      #20000;
      error_cnt++;
      complete_run();
   end
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, timer_f_16bit_mode} = 3'h0;
      {event_16bit_mode, event_counter_irq_pin, capture_input_pin} = 3'h0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      s_axi_wstrb = 4'hF;
      external_irq_pin = 4'h0;
      direct_transfer_on = 1'b1;
      overflow_irq_enable = 1'b1;
      conversion_start_flag = 1'b1;
      {timer_f_counter_high, timer_f_compare_high} = 16'h0002;
      {timer_f_counter_low, timer_f_compare_low} = 16'h0001;
      wakeup_pin = 8'hF0;
      lf = 8'h0C;
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      rd(IRF_OFS_REQ_A, 32'h20);
      rd(IRF_OFS_REQ_B, 32'h00);
      rd(IRF_OFS_WAKE, 32'h00);
      rd(IRF_OFS_EDGE, 32'h00);
      $display("test reset values done");
      irf_src_inst.fire(7'h01);
      rd(IRF_OFS_REQ_A, 32'hA0);
      for (int i = 0; i < 3; i++) begin
         lf = lfsr(lf);
         wr(IRF_OFS_REQ_A, {24'h0, (lf & 8'hBF) | 8'h80});
      end
      rd(IRF_OFS_REQ_A, 32'hA0);
      // clear write and overflow land on the same edge
      fork
         wr(IRF_OFS_REQ_A, 32'h00);
         irf_src_inst.fire(7'h01);
      join
      rd(IRF_OFS_REQ_A, 32'hA0);
      wr(IRF_OFS_REQ_A, 32'h00);
      rd(IRF_OFS_REQ_A, 32'h20);
      $display("test timer a flag done");
      irf_src_inst.fire(7'h56);
      conversion_start_flag <= 1'b0;
      timer_f_counter_low <= 8'h01;
      timer_f_counter_high <= 8'h02;
      repeat (4) @(posedge clk_sys);
      rd(IRF_OFS_REQ_B, 32'hDF);
      wr(IRF_OFS_REQ_B, 32'h00);
      rd(IRF_OFS_REQ_B, 32'h00);
      // low byte overflow must not count in 16-bit mode
      event_16bit_mode <= 1'b1;
      irf_src_inst.fire(7'h40);
      rd(IRF_OFS_REQ_B, 32'h00);
      $display("test peripheral flags done");
      wr(IRF_OFS_EDGE, 32'h0F);
      wr(IRF_OFS_PIN_ASSIGN, 32'hFFFF);
      wr(IRF_OFS_PIN_EDGE, 32'h5F);
      wr(IRF_OFS_EN_A, 32'hFF);
      rd(IRF_OFS_EDGE, 32'h0F);
      wakeup_pin <= 8'h0F;
      external_irq_pin <= 4'hF;
      event_counter_irq_pin <= 1'b1;
      capture_input_pin <= 1'b1;
      repeat (8) @(posedge clk_sys);
      rd(IRF_OFS_WAKE, 32'hFF);
      rd(IRF_OFS_REQ_A, 32'h3F);
      rd(IRF_OFS_REQ_B, 32'h10);
      chk({26'h0, irq_request_a}, 34'h3F);
      chk({26'h0, irq_request_b}, 34'h00);
      wr(IRF_OFS_WAKE, 32'h00);
      rd(IRF_OFS_WAKE, 32'h00);
      rd(32'h20, 32'h00);
      $display("test pins and unmapped done");
      @(posedge clk_sys);
      complete_run();
   end
endmodule
